//--- logic/bus_line_monitor.sv
// link-domain pin sampling and start/stop detection
module bus_line_monitor (
   input  wire logic link_clk,
   input  wire logic rst,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      scl_level,
   output logic      sda_level,
   output logic      start_toggle,
   output logic      stop_toggle
);

   logic rst_meta_q;
   logic rst_link_q;
   logic scl_meta_q;
   logic sda_meta_q;
   logic scl_prev_q;
   logic sda_prev_q;
   wire  start_det;
   wire  stop_det;

   // sda edge while scl stays high marks a start or a stop
   assign start_det = scl_level && scl_prev_q && sda_prev_q && !sda_level;
   assign stop_det  = scl_level && scl_prev_q && !sda_prev_q && sda_level;

   always_ff @(posedge link_clk) begin
      rst_meta_q <= rst;
      rst_link_q <= rst_meta_q;
   end

   always_ff @(posedge link_clk) begin
      scl_meta_q <= scl_in;
      sda_meta_q <= sda_in;
      scl_level  <= scl_meta_q;
      sda_level  <= sda_meta_q;
   end

   // toggles so a single-cycle event survives the slower core clock
   always_ff @(posedge link_clk) begin
      if (rst_link_q) begin
         scl_prev_q   <= 1'b1;
         sda_prev_q   <= 1'b1;
         start_toggle <= 1'b0;
         stop_toggle  <= 1'b0;
      end else begin
         scl_prev_q   <= scl_level;
         sda_prev_q   <= sda_level;
         start_toggle <= start_toggle ^ start_det;
         stop_toggle  <= stop_toggle ^ stop_det;
      end
   end

endmodule : bus_line_monitor

//--- logic/smbus_cfg_pkg.sv
// shared constants and types for the bus clock and configuration block
package smbus_cfg_pkg;

   // register placement and reset value
   localparam logic [7:0] CFG_ADDR       = 8'hc1;
   localparam logic [7:0] CFG_RESET      = 8'h00;
   localparam logic [7:0] CFG_WRITE_MASK = 8'hdf;

   // field positions inside bus_clock_config
   localparam int EN_BIT   = 7;
   localparam int INH_BIT  = 6;
   localparam int BUSY_BIT = 5;
   localparam int HOLD_BIT = 4;
   localparam int TOE_BIT  = 3;
   localparam int FTE_BIT  = 2;
   localparam int SEL_LSB  = 0;

   // bit_clock_source_select codes
   localparam logic [1:0] SRC_TIMER0      = 2'h0;
   localparam logic [1:0] SRC_TIMER1      = 2'h1;
   localparam logic [1:0] SRC_TIMER2_HIGH = 2'h2;
   localparam logic [1:0] SRC_TIMER2_LOW  = 2'h3;

   // sda timing in core_clock cycles
   localparam logic [3:0] HOLD_STD  = 4'h3;
   localparam logic [3:0] HOLD_EXT  = 4'hc;
   localparam logic [3:0] SETUP_STD = 4'h1;
   localparam logic [3:0] SETUP_EXT = 4'hb;

   // scl high phase and free timeout in overflow ticks
   localparam logic [1:0] HIGH_TICKS = 2'h2;
   localparam logic [3:0] FREE_TICKS = 4'ha;

   typedef enum logic [6:0] {
      ST_IDLE      = 7'h01,
      ST_WAIT_FREE = 7'h02,
      ST_START     = 7'h04,
      ST_LOW       = 7'h08,
      ST_HIGH      = 7'h10,
      ST_STOP_LOW  = 7'h20,
      ST_STOP_HIGH = 7'h40
   } master_state_e;

endpackage : smbus_cfg_pkg

//--- logic/smbus_config_timing.sv
// bus clock generation, configuration register and timeout logic of the two-wire interface
// What this block does
// - enable bit turns on master and slave handling and line monitoring.
// - slave inhibit keeps monitoring but NACKs addresses and hides slave interrupts.
// - slave inhibit becomes effective only at the next detected START.
// - slave inhibit never touches master-mode interrupts.
// - two-bit select picks timer 0, 1, 2 high or 2 low overflow.
// - the selected tick is used only as master or with free timeout.
// - each master SCL low and high phase lasts at least one tick.
// - unstretched bit is about three ticks, high twice the low.
// - never exceed the minimum-time rate; stretch phases when others hold SCL.
// - SDA setup/hold of 1 and 3 clocks, or 11 and 12 extended.
// - setup applies to ack and first data bits, including software delay.
// - with SCL timeout enabled, timer 3 reloads while SCL high.
// - bus is free after more than 10 idle-high ticks.
// - busy bit set during transfers, cleared by STOP or free timeout.
// - a pending START goes out as soon as the bus is free.
// - with timer 3 split only its upper half is held in reload.
// - byte event flag holds SCL low until software clears it.
module smbus_config_timing (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       link_clk,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rd_data,
   input  wire logic       timer0_ovf,
   input  wire logic       timer1_ovf,
   input  wire logic       timer2_high_ovf,
   input  wire logic       timer2_low_ovf,
   input  wire logic       timer3_split,
   input  wire logic       start_request,
   input  wire logic       stop_request,
   input  wire logic       byte_event_flag,
   input  wire logic       tx_sda_bit,
   input  wire logic       slave_event,
   input  wire logic       master_event,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            scl_out,
   output logic            scl_oe,
   output logic            sda_out,
   output logic            sda_oe,
   output logic            busy,
   output logic            master_active,
   output logic            bit_sample,
   output logic            sda_sample,
   output logic            start_seen,
   output logic            stop_seen,
   output logic            arb_lost,
   output logic            free_timeout,
   output logic            slave_nack_force,
   output logic            event_irq,
   output logic            timer3_reload_high,
   output logic            timer3_reload_low
);

   smbus_cfg_pkg::master_state_e state_q;
   smbus_cfg_pkg::master_state_e state_d;

   logic [7:0] cfg_q;
   logic       scl_lvl_link;
   logic       sda_lvl_link;
   logic       start_tgl_link;
   logic       stop_tgl_link;
   logic       scl_meta_q;
   logic       scl_s_q;
   logic       sda_meta_q;
   logic       sda_s_q;
   logic       start_meta_q;
   logic       start_sync_q;
   logic       start_prev_q;
   logic       stop_meta_q;
   logic       stop_sync_q;
   logic       stop_prev_q;
   logic       inh_eff_q;
   logic [3:0] free_cnt_q;
   logic [3:0] hold_cnt_q;
   logic [3:0] setup_cnt_q;
   logic [1:0] high_cnt_q;
   logic       placed_q;
   logic       low_tick_q;
   logic       sda_oe_d;

   bus_line_monitor u_monitor (
      .link_clk     (link_clk),
      .rst          (rst),
      .scl_in       (scl_in),
      .sda_in       (sda_in),
      .scl_level    (scl_lvl_link),
      .sda_level    (sda_lvl_link),
      .start_toggle (start_tgl_link),
      .stop_toggle  (stop_tgl_link)
   );

   // configuration fields
   wire       en       = cfg_q[smbus_cfg_pkg::EN_BIT];
   wire       slave_inhibit      = cfg_q[smbus_cfg_pkg::INH_BIT];
   wire       ext_hold = cfg_q[smbus_cfg_pkg::HOLD_BIT];
   wire       toe      = cfg_q[smbus_cfg_pkg::TOE_BIT];
   wire       fte      = cfg_q[smbus_cfg_pkg::FTE_BIT];
   wire [1:0] src_sel  = cfg_q[smbus_cfg_pkg::SEL_LSB +: 2];

   // register access decode
   wire       cfg_hit  = (sfr_addr == smbus_cfg_pkg::CFG_ADDR);
   wire       cfg_wr   = sfr_wr && cfg_hit;
   wire [7:0] cfg_view = (cfg_q & smbus_cfg_pkg::CFG_WRITE_MASK) | ({7'h00, busy} << smbus_cfg_pkg::BUSY_BIT);

   // tick selection
   wire [3:0] ovf_vec  = {timer2_low_ovf, timer2_high_ovf, timer1_ovf, timer0_ovf};
   wire       sel_tick = ovf_vec[src_sel];
   wire       master_act = (state_q != smbus_cfg_pkg::ST_IDLE) && (state_q != smbus_cfg_pkg::ST_WAIT_FREE);
   wire       tick = sel_tick && en && (master_act || fte);

   // bus events in the core clock domain
   wire       start_ev = start_sync_q ^ start_prev_q;
   wire       stop_ev  = stop_sync_q ^ stop_prev_q;
   wire       lines_high = scl_s_q && sda_s_q;
   wire       free_hit = tick && fte && lines_high && (free_cnt_q == smbus_cfg_pkg::FREE_TICKS);

   // sda timing figures
   wire [3:0] hold_min  = ext_hold ? smbus_cfg_pkg::HOLD_EXT : smbus_cfg_pkg::HOLD_STD;
   wire [3:0] setup_min = ext_hold ? smbus_cfg_pkg::SETUP_EXT : smbus_cfg_pkg::SETUP_STD;
   wire       in_low    = (state_q == smbus_cfg_pkg::ST_LOW);
   wire       place_now = in_low && !scl_s_q && !placed_q && (hold_cnt_q >= hold_min);
   wire       setup_ok  = placed_q && (setup_cnt_q >= setup_min);
   // byte event flag keeps the low phase open, so any software delay adds to setup
   wire       low_done  = low_tick_q && setup_ok && !byte_event_flag;
   wire       high_done = scl_s_q && tick && (high_cnt_q == smbus_cfg_pkg::HIGH_TICKS - 2'h1);
   wire       lost_now  = (state_q == smbus_cfg_pkg::ST_HIGH) && scl_s_q && !sda_oe && !sda_s_q;

   // master sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         smbus_cfg_pkg::ST_IDLE: begin
            if (en && start_request) begin
               state_d = smbus_cfg_pkg::ST_WAIT_FREE;
            end
         end
         smbus_cfg_pkg::ST_WAIT_FREE: begin
            if (!en) begin
               state_d = smbus_cfg_pkg::ST_IDLE;
            end else if (!busy && lines_high) begin
               state_d = smbus_cfg_pkg::ST_START;
            end
         end
         smbus_cfg_pkg::ST_START: begin
            if (!en) begin
               state_d = smbus_cfg_pkg::ST_IDLE;
            end else if (tick) begin
               state_d = smbus_cfg_pkg::ST_LOW;
            end
         end
         smbus_cfg_pkg::ST_LOW: begin
            if (!en) begin
               state_d = smbus_cfg_pkg::ST_IDLE;
            end else if (low_done) begin
               state_d = stop_request ? smbus_cfg_pkg::ST_STOP_LOW : smbus_cfg_pkg::ST_HIGH;
            end
         end
         smbus_cfg_pkg::ST_HIGH: begin
            if (!en || lost_now) begin
               state_d = smbus_cfg_pkg::ST_IDLE;
            end else if (high_done) begin
               state_d = smbus_cfg_pkg::ST_LOW;
            end
         end
         smbus_cfg_pkg::ST_STOP_LOW: begin
            if (!en) begin
               state_d = smbus_cfg_pkg::ST_IDLE;
            end else if (tick) begin
               state_d = smbus_cfg_pkg::ST_STOP_HIGH;
            end
         end
         smbus_cfg_pkg::ST_STOP_HIGH: begin
            if (!en || (scl_s_q && tick)) begin
               state_d = smbus_cfg_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = smbus_cfg_pkg::ST_IDLE;
         end
      endcase
   end

   // sda drive follows the sequence; data moves only after the hold time
   always_comb begin
      sda_oe_d = sda_oe;
      if (!en) begin
         sda_oe_d = 1'b0;
      end else if ((state_d == smbus_cfg_pkg::ST_IDLE) || (state_d == smbus_cfg_pkg::ST_WAIT_FREE)) begin
         sda_oe_d = 1'b0;
      end else if ((state_d == smbus_cfg_pkg::ST_START) || (state_d == smbus_cfg_pkg::ST_STOP_LOW)) begin
         sda_oe_d = 1'b1;
      end else if (place_now && (state_d == smbus_cfg_pkg::ST_LOW)) begin
         sda_oe_d = !tx_sda_bit;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= smbus_cfg_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // configuration register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_q       <= smbus_cfg_pkg::CFG_RESET;
         sfr_rd_data <= 8'h00;
      end else begin
         if (cfg_wr) begin
            cfg_q <= sfr_wdata & smbus_cfg_pkg::CFG_WRITE_MASK;
         end
         sfr_rd_data <= cfg_hit ? cfg_view : 8'h00;
      end
   end

   // both stages of each crossing from the link domain
   always_ff @(posedge sys_clk) begin
      scl_meta_q   <= scl_lvl_link;
      scl_s_q      <= scl_meta_q;
      sda_meta_q   <= sda_lvl_link;
      sda_s_q      <= sda_meta_q;
      start_meta_q <= start_tgl_link;
      start_sync_q <= start_meta_q;
      stop_meta_q  <= stop_tgl_link;
      stop_sync_q  <= stop_meta_q;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         start_prev_q <= 1'b0;
         stop_prev_q  <= 1'b0;
         start_seen   <= 1'b0;
         stop_seen    <= 1'b0;
      end else begin
         start_prev_q <= start_sync_q;
         stop_prev_q  <= stop_sync_q;
         start_seen   <= en && start_ev;
         stop_seen    <= en && stop_ev;
      end
   end

   // busy and free timeout
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busy         <= 1'b0;
         free_cnt_q   <= 4'h0;
         free_timeout <= 1'b0;
      end else begin
         if (!en) begin
            busy <= 1'b0;
         end else if (start_ev) begin
            busy <= 1'b1;
         end else if (stop_ev || free_hit) begin
            busy <= 1'b0;
         end
         if (!en || !fte || !lines_high) begin
            free_cnt_q <= 4'h0;
         end else if (tick && (free_cnt_q != smbus_cfg_pkg::FREE_TICKS)) begin
            free_cnt_q <= free_cnt_q + 4'h1;
         end
         free_timeout <= free_hit;
      end
   end

   // low and high phase bookkeeping
   always_ff @(posedge sys_clk) begin
      if (rst || !in_low) begin
         hold_cnt_q  <= 4'h0;
         setup_cnt_q <= 4'h0;
         placed_q    <= 1'b0;
         low_tick_q  <= 1'b0;
      end else begin
         // hold counts only once the line is really low
         if (!scl_s_q && (hold_cnt_q != 4'hf)) begin
            hold_cnt_q <= hold_cnt_q + 4'h1;
         end
         if (place_now) begin
            placed_q <= 1'b1;
         end
         if (placed_q && (setup_cnt_q != 4'hf)) begin
            setup_cnt_q <= setup_cnt_q + 4'h1;
         end
         if (tick) begin
            low_tick_q <= 1'b1;
         end
      end
   end

   // high time counts only ticks seen with scl really high
   always_ff @(posedge sys_clk) begin
      if (rst || (state_q != smbus_cfg_pkg::ST_HIGH)) begin
         high_cnt_q <= 2'h0;
      end else if (scl_s_q && tick) begin
         high_cnt_q <= high_cnt_q + 2'h1;
      end
   end

   // pins and master status
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         scl_out       <= 1'b0;
         sda_out       <= 1'b0;
         scl_oe        <= 1'b0;
         sda_oe        <= 1'b0;
         master_active <= 1'b0;
         bit_sample    <= 1'b0;
         sda_sample    <= 1'b1;
         arb_lost      <= 1'b0;
      end else begin
         scl_out       <= 1'b0;
         sda_out       <= 1'b0;
         scl_oe        <= en && ((state_d == smbus_cfg_pkg::ST_LOW) ||
                                 (state_d == smbus_cfg_pkg::ST_STOP_LOW));
         sda_oe        <= sda_oe_d;
         master_active <= en && (state_d != smbus_cfg_pkg::ST_IDLE) && (state_d != smbus_cfg_pkg::ST_WAIT_FREE);
         bit_sample    <= en && high_done && !lost_now;
         if (high_done) begin
            sda_sample <= sda_s_q;
         end
         arb_lost      <= en && lost_now;
      end
   end

   // slave inhibit latched at each start, so the running transfer keeps its events
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         inh_eff_q        <= 1'b0;
         slave_nack_force <= 1'b0;
         event_irq        <= 1'b0;
      end else begin
         if (!en) begin
            inh_eff_q <= 1'b0;
         end else if (start_ev) begin
            inh_eff_q <= slave_inhibit;
         end
         slave_nack_force <= en && inh_eff_q;
         event_irq        <= en && (master_event || (slave_event && !inh_eff_q && !master_act));
      end
   end

   // timer 3 reload while scl is high
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         timer3_reload_high <= 1'b0;
         timer3_reload_low  <= 1'b0;
      end else begin
         timer3_reload_high <= en && toe && scl_s_q;
         timer3_reload_low  <= en && toe && scl_s_q && !timer3_split;
      end
   end

endmodule : smbus_config_timing

//--- testbench/smbus_config_timing_chk.sv
// concurrent checks on the ports of the bus clock and configuration block
module smbus_config_timing_chk (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       timer0_ovf,
   input wire logic       timer1_ovf,
   input wire logic       timer2_high_ovf,
   input wire logic       timer2_low_ovf,
   input wire logic       timer3_split,
   input wire logic       slave_event,
   input wire logic       master_event,
   input wire logic       scl_oe,
   input wire logic       sda_oe,
   input wire logic       busy,
   input wire logic       master_active,
   input wire logic       bit_sample,
   input wire logic       stop_seen,
   input wire logic       start_seen,
   input wire logic       free_timeout,
   input wire logic       slave_nack_force,
   input wire logic       event_irq,
   input wire logic       timer3_reload_high,
   input wire logic       timer3_reload_low
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [7:0] cfg_q, lo_q, hi_q, age_q;
   logic       sda_p_q;
   wire  [3:0] ovf  = {timer2_low_ovf, timer2_high_ovf, timer1_ovf, timer0_ovf};
   wire        tick = ovf[cfg_q[1:0]];
   // shadow of the config register, ticks per scl phase, sda age
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_q <= 8'h00;
      end else if (sfr_wr && sfr_addr == 8'hc1) begin
         cfg_q <= sfr_wdata;
      end
   end
   always_ff @(posedge sys_clk) begin
      lo_q    <= (rst || !scl_oe) ? 8'h00 : lo_q + {7'h00, tick && lo_q != 8'hff};
      hi_q    <= (rst || scl_oe) ? 8'h00 : hi_q + {7'h00, tick && hi_q != 8'hff};
      age_q   <= (rst || sda_oe != sda_p_q) ? 8'h00 : age_q + {7'h00, age_q != 8'hff};
      sda_p_q <= sda_oe;
   end
   sequence off_run;
      !cfg_q[7] [*3];
   endsequence
   sequence scl_pull;
      $rose(scl_oe) && master_active;
   endsequence
   disabled_quiet_a: assert property (off_run |-> !scl_oe && !sda_oe && !master_active && !busy)
      else $error("activity while disabled");
   low_phase_a: assert property ($fell(scl_oe) && master_active |-> lo_q >= 8'h01)
      else $error("scl low phase shorter than one tick");
   high_phase_a: assert property (bit_sample |-> hi_q >= 8'h02 || $past(hi_q) >= 8'h02)
      else $error("scl high phase shorter than two ticks");
   setup_ext_a: assert property ($fell(scl_oe) && master_active && cfg_q[4] |-> age_q >= 8'h0a)
      else $error("extended sda setup too short");
   hold_std_a: assert property (scl_pull |=> $stable(sda_oe) [*3])
      else $error("sda hold too short");
   hold_ext_a: assert property (scl_pull and cfg_q[4] |=> $stable(sda_oe) [*8])
      else $error("extended sda hold too short");
   master_irq_a: assert property (master_event && cfg_q[7] |=> event_irq)
      else $error("master event lost");
   slave_mute_a: assert property (slave_event && !master_event && slave_nack_force && !master_active
      |=> !event_irq)
      else $error("slave event not suppressed");
   busy_set_a: assert property (start_seen |-> ##[0:1] busy)
      else $error("busy not set on start");
   busy_clr_a: assert property ((stop_seen || free_timeout) && !start_seen |-> ##[0:1] !busy)
      else $error("busy not cleared");
   reload_off_a: assert property (!cfg_q[3] [*3] |-> !timer3_reload_high && !timer3_reload_low)
      else $error("timer reload without timeout enable");
   split_reload_a: assert property (timer3_split [*3] |-> !timer3_reload_low)
      else $error("low half reloaded in split mode");
   free_off_a: assert property (!cfg_q[2] [*3] |-> !free_timeout)
      else $error("free timeout while detection disabled");
endmodule : smbus_config_timing_chk

bind smbus_config_timing smbus_config_timing_chk chk_u (
   .sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .timer0_ovf, .timer1_ovf, .timer2_high_ovf,
   .timer2_low_ovf, .timer3_split, .slave_event, .master_event, .scl_oe, .sda_oe, .busy,
   .master_active, .bit_sample, .stop_seen, .start_seen, .free_timeout, .slave_nack_force,
   .event_irq, .timer3_reload_high, .timer3_reload_low
);

//--- testbench/smbus_config_timing_tb.sv
// testbench for the bus clock and configuration block
module smbus_config_timing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk, link_clk, rst, sfr_wr, timer3_split, start_request, stop_request;
   logic       byte_event_flag, tx_sda_bit, slave_event, master_event, scl_in, sda_in;
   logic       scl_oe, sda_oe, busy, master_active, bit_sample, start_seen, stop_seen, sda_sample;
   logic       free_timeout, slave_nack_force, event_irq, timer3_reload_high, timer3_reload_low;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rd_data, rdv;
   logic [3:0] ovf;
   int         fails, n_checks, c;
   int         tcnt = 0;
   int         per[4] = '{16, 32, 64, 128};
   smbus_config_timing dut_u (
      .sys_clk, .rst, .link_clk, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd_data,
      .timer0_ovf(ovf[0]), .timer1_ovf(ovf[1]), .timer2_high_ovf(ovf[2]), .timer2_low_ovf(ovf[3]),
      .timer3_split, .start_request, .stop_request, .byte_event_flag, .tx_sda_bit, .slave_event,
      .master_event, .scl_in, .sda_in, .scl_out(), .scl_oe, .sda_out(), .sda_oe, .busy, .master_active,
      .bit_sample, .sda_sample, .start_seen, .stop_seen, .arb_lost(), .free_timeout, .slave_nack_force,
      .event_irq, .timer3_reload_high, .timer3_reload_low
   );
   smbus_peer_model peer_u (.link_clk, .scl_oe, .sda_oe, .scl_in, .sda_in);
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #15 link_clk = ~link_clk;
   end
   // four free-running timers, far apart so a wrong source shows in the bit rate
   always @(posedge sys_clk) begin
      tcnt <= tcnt + 1;
      for (int k = 0; k < 4; k++) ovf[k] <= (tcnt % per[k]) == per[k] - 1;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic chkr(input int v, input int lo, input int hi);
      n_checks++;
      if (v < lo || v > hi) begin
         fails++;
         $display("BAD %0t count %0d outside %0d..%0d", $time, v, lo, hi);
      end
   endtask : chkr
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      sfr_addr <= a;
      repeat (2) @(negedge sys_clk);
      rdv = sfr_rd_data;
   endtask : rd
   // 0 bit_sample, 1 stop_seen, 2 free_timeout, 3 start_seen; cycles left in c
   task automatic wt(input int k);
      logic s;
      c = 0;
      do begin
         @(negedge sys_clk);
         c++;
         s = k == 0 ? bit_sample : k == 1 ? stop_seen : k == 2 ? free_timeout : start_seen;
      end while (s !== 1'b1 && c < 4000);
      if (c >= 4000) begin
         fails++;
         $display("BAD %0t no event %0d", $time, k);
      end
   endtask : wt
   task automatic ev(input logic s, input logic m, input logic e);
      @(posedge sys_clk);
      slave_event  <= s;
      master_event <= m;
      @(posedge sys_clk);
      slave_event  <= 1'b0;
      master_event <= 1'b0;
      @(negedge sys_clk);
      chk({7'h00, event_irq}, {7'h00, e});
   endtask : ev
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (40000) @(posedge sys_clk);
      fails++;
      $display("BAD %0t watchdog expired", $time);
      final_report();
   end
   initial begin
      {rst, sfr_wr, timer3_split, start_request, stop_request, byte_event_flag} = 6'h20;
      {slave_event, master_event, tx_sda_bit, sfr_addr, sfr_wdata} = 19'h0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      wr(8'hc0, 8'hff);
      rd(8'hc1);
      chk(rdv, 8'h00);
      rd(8'hc0);
      chk(rdv, 8'h00);
      wr(8'hc1, 8'h7f);
      rd(8'hc1);
      chk(rdv, 8'h5f);
      $display("test register access done");
      for (int s = 0; s < 4; s++) begin
         wr(8'hc1, {3'b100, s[0], 2'b00, s[1:0]});
         @(posedge sys_clk);
         start_request <= 1'b1;
         tx_sda_bit    <= s[1];
         wt(3);
         rd(8'hc1);
         chk(rdv, {3'b101, s[0], 2'b00, s[1:0]});
         @(posedge sys_clk);
         start_request <= 1'b0;
         wt(0);
         wt(0);
         chkr(c, 3 * per[s] - 8, 3 * per[s] + 16);
         chk({7'h00, sda_sample}, {7'h00, s[1]});
         @(posedge sys_clk);
         stop_request <= 1'b1;
         wt(1);
         @(posedge sys_clk);
         stop_request <= 1'b0;
         rd(8'hc1);
         chk(rdv, {3'b100, s[0], 2'b00, s[1:0]});
         $display("test clock source %0d done", s);
      end
      wr(8'hc1, 8'h80);
      @(posedge sys_clk);
      start_request <= 1'b1;
      wt(3);
      @(posedge sys_clk);
      start_request   <= 1'b0;
      byte_event_flag <= 1'b1;
      repeat (200) @(negedge sys_clk);
      chk({7'h00, scl_oe}, 8'h01);
      @(posedge sys_clk);
      byte_event_flag <= 1'b0;
      wt(0);
      fork
         peer_u.stretch(200);
      join_none
      wt(0);
      // 60-cycle stretch, then two ticks on the 16-cycle grid with scl seen high
      chkr(c, 76, 100);
      // drop enable in mid-transfer, the bus must come back released
      wr(8'hc1, 8'h00);
      repeat (3) @(negedge sys_clk);
      chk({4'h0, scl_oe, sda_oe, master_active, busy}, 8'h00);
      $display("test stall and stretch done");
      wr(8'hc1, 8'h8c);
      repeat (10) @(negedge sys_clk);
      chk({6'h00, timer3_reload_high, timer3_reload_low}, 8'h03);
      peer_u.drive(1'b0, 1'b1, 10);
      peer_u.drive(1'b1, 1'b1, 20);
      chk({6'h00, timer3_reload_high, timer3_reload_low}, 8'h00);
      rd(8'hc1);
      chk(rdv, 8'hac);
      @(posedge sys_clk);
      timer3_split <= 1'b1;
      peer_u.drive(1'b1, 1'b0, 5);
      peer_u.drive(1'b0, 1'b0, 20);
      chk({6'h00, timer3_reload_high, timer3_reload_low}, 8'h02);
      @(posedge sys_clk);
      start_request <= 1'b1;
      wt(2);
      chkr(c, 144, 184);
      wt(3);
      chkr(c, 1, 40);
      @(posedge sys_clk);
      start_request <= 1'b0;
      stop_request  <= 1'b1;
      timer3_split  <= 1'b0;
      wt(1);
      @(posedge sys_clk);
      stop_request <= 1'b0;
      $display("test timeouts done");
      wr(8'hc1, 8'hc0);
      ev(1'b1, 1'b0, 1'b1);
      chk({7'h00, slave_nack_force}, 8'h00);
      peer_u.drive(1'b0, 1'b1, 10);
      peer_u.drive(1'b0, 1'b0, 20);
      chk({7'h00, slave_nack_force}, 8'h01);
      ev(1'b1, 1'b0, 1'b0);
      ev(1'b0, 1'b1, 1'b1);
      $display("test slave inhibit done");
      final_report();
   end
endmodule : smbus_config_timing_tb

//--- testbench/smbus_peer_model.sv
// open-drain partner: pull-ups plus one other master or slave on scl and sda
module smbus_peer_model (
   input  wire logic link_clk,
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   output logic      scl_in,
   output logic      sda_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic scl_low_q = 1'b0;
   logic sda_low_q = 1'b0;
   // wired-and with pull-ups, so a released line reads high
   assign scl_in = !(scl_oe || scl_low_q);
   assign sda_in = !(sda_oe || sda_low_q);
   task automatic drive(input logic c, input logic d, input int n);
      @(posedge link_clk);
      scl_low_q <= c;
      sda_low_q <= d;
      repeat (n) @(posedge link_clk);
   endtask : drive
   // slow slave holding the clock low once the master has pulled it
   task automatic stretch(input int n);
      @(posedge link_clk iff scl_oe);
      scl_low_q <= 1'b1;
      repeat (n) @(posedge link_clk);
      scl_low_q <= 1'b0;
   endtask : stretch
endmodule : smbus_peer_model
